/* File: hdl/ssa_pkg.sv */
// constants, field layouts and carrier types of the smi source aggregator
package ssa_pkg;

   // register offsets on the host port
   localparam logic [7:0] OFF_GLB_STS = 8'h10;
   localparam logic [7:0] OFF_GLB_EN = 8'h11;
   localparam logic [7:0] OFF_STS_FIRST = 8'h12;
   localparam logic [7:0] OFF_STS_SECOND = 8'h13;
   localparam logic [7:0] OFF_STS_GPIO = 8'h14;
   localparam logic [7:0] OFF_EN_FIRST = 8'h15;
   localparam logic [7:0] OFF_EN_SECOND = 8'h16;
   localparam logic [7:0] OFF_EN_GPIO = 8'h17;
   localparam logic [7:0] OFF_IRQ_STS = 8'h18;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h19;
   localparam logic [7:0] OFF_IRQ_EN = 8'h1A;

   // field positions in the second status, second enable and global registers
   localparam int unsigned BIT_MOUSE = 0;
   localparam int unsigned BIT_KBD = 1;
   localparam int unsigned BIT_RSVD = 2;
   localparam int unsigned BIT_WDT = 3;
   localparam int unsigned BIT_INTR = 4;
   localparam int unsigned BIT_ROUTE_WAKE = 5;
   localparam int unsigned BIT_ROUTE_SERIRQ = 6;
   localparam int unsigned BIT_ROUTE_PIN = 7;
   localparam int unsigned BIT_GLB = 0;

   // masks of the second registers
   localparam logic [7:0] EN2_WR_MASK = 8'hFB;
   localparam logic [7:0] SRC2_MASK = 8'h1B;

   // host interrupt status layout
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_GLB = 0;
   localparam int unsigned IRQ_GPIO = 1;
   localparam int unsigned IRQ_WDT = 2;

   // values after reset
   localparam logic [7:0] RST_EN_FIRST = 8'h00;
   localparam logic [7:0] RST_EN_SECOND = 8'h00;
   localparam logic [7:0] RST_EN_GPIO = 8'h00;
   localparam logic [7:0] RST_STS_GPIO = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

   // per-pin interrupt detection setting
   typedef enum logic [2:0] {
      DET_LEVEL_LOW = 3'h0,
      DET_LEVEL_HIGH = 3'h1,
      DET_NONE = 3'h4,
      DET_RISE = 3'h5,
      DET_FALL = 3'h6,
      DET_BOTH = 3'h7
   } ssa_det_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssa_bus_t;

   typedef struct packed {
      logic [7:0] first;
      logic mouse_irq;
      logic kbd_irq;
      logic wd_expired;
      logic intrusion;
   } ssa_src_t;

endpackage

/* File: hdl/ssa_top.sv */
// smi source aggregator: status, enables, routing and host register port
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module ssa_top
   import ssa_pkg::*;
(
   input wire logic clk_sys,            // system clock, 100 MHz
   input wire logic nrst,               // synchronous reset, active low
   input wire ssa_bus_t bus,            // host register request
   output logic [7:0] rd_data,          // read data, cycle after read
   input wire ssa_src_t src,            // interrupt sources from other units
   input wire logic [7:0] gpio_pin,     // monitored gpio pin levels
   input wire ssa_det_t [7:0] gpio_det, // detection setting per pin
   output logic sys_mgmt_irq_n_pin,     // dedicated smi pin, active low
   output logic serirq_smi,             // smi request to serial irq
   output logic wake_devint,            // device interrupt to wake status
   output logic irq                     // host interrupt, level
);

   logic [7:0] rd_data_q;
   logic mouse_irq_flag_q;
   logic keyboard_irq_flag_q;
   logic watchdog_timeout_flag_q;
   logic intrusion_q;
   logic [7:0] global_event_flag_first_q;
   logic [7:0] global_event_flag_second;
   logic [7:0] global_event_flag_gpio_q;
   logic [7:0] global_event_enable_first_q;
   logic [7:0] global_event_enable_second_q;
   logic [7:0] global_event_enable_gpio_q;
   logic global_event_flag_q;
   logic global_event_enable_q;
   logic [7:0] pin_q;
   ssa_det_t [7:0] det_q;
   logic [7:0] edge_sel;
   logic [7:0] gpio_set;
   logic pending;
   logic smi_func;
   logic smi_pin_n_q;
   logic serirq_q;
   logic wake_q;
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic [IRQ_W-1:0] irq_ev;

   function automatic logic wr_hit(input ssa_bus_t b, input logic [7:0] off);
      wr_hit = b.wr && (b.addr == off);
   endfunction

   // mirrored sources, taken one cycle after the source changes
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mouse_irq_flag_q <= 1'b0;
         keyboard_irq_flag_q <= 1'b0;
         intrusion_q <= 1'b0;
         global_event_flag_first_q <= RST_BYTE;
      end else begin
         mouse_irq_flag_q <= src.mouse_irq;
         keyboard_irq_flag_q <= src.kbd_irq;
         intrusion_q <= src.intrusion;
         global_event_flag_first_q <= src.first;
      end
   end

   // watchdog flag: a timeout in the clearing cycle wins
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         watchdog_timeout_flag_q <= 1'b0;
      end else if (src.wd_expired) begin
         watchdog_timeout_flag_q <= 1'b1;
      end else if (wr_hit(bus, OFF_STS_SECOND) && bus.wdata[BIT_WDT]) begin
         watchdog_timeout_flag_q <= 1'b0;
      end
   end

   always_comb begin
      global_event_flag_second = RST_BYTE;
      global_event_flag_second[BIT_MOUSE] = mouse_irq_flag_q;
      global_event_flag_second[BIT_KBD] = keyboard_irq_flag_q;
      global_event_flag_second[BIT_RSVD] = 1'b1;
      global_event_flag_second[BIT_WDT] = watchdog_timeout_flag_q;
      global_event_flag_second[BIT_INTR] = intrusion_q;
   end

   // gpio edge detection; index 0..7 is GPIO21,24,25,31,35,53,54,62
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_q <= RST_BYTE;
         det_q <= '{default: DET_NONE};
      end else begin
         pin_q <= gpio_pin;
         det_q <= gpio_det;
      end
   end

   for (genvar i = 0; i < 8; i++) begin : g_gpio
      logic rise;
      logic fall;
      logic hit;
      logic arm;
      assign rise = gpio_pin[i] && !pin_q[i];
      assign fall = !gpio_pin[i] && pin_q[i];
      // level settings never produce an event
      assign edge_sel[i] = (gpio_det[i] == DET_RISE) ||
                           (gpio_det[i] == DET_FALL) ||
                           (gpio_det[i] == DET_BOTH);
      assign hit = ((gpio_det[i] == DET_RISE) && rise) ||
                   ((gpio_det[i] == DET_FALL) && fall) ||
                   ((gpio_det[i] == DET_BOTH) && (rise || fall));
      // arming an edge mode from DET_NONE while the pin is high reports an event
      assign arm = (det_q[i] == DET_NONE) && edge_sel[i] &&
                   gpio_pin[i];
      assign gpio_set[i] = hit || arm;
   end

   // gpio status: write one clears, a new event in the same cycle wins
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         global_event_flag_gpio_q <= RST_STS_GPIO;
      end else if (wr_hit(bus, OFF_STS_GPIO)) begin
         global_event_flag_gpio_q <= (global_event_flag_gpio_q & ~bus.wdata) |
                              gpio_set;
      end else begin
         global_event_flag_gpio_q <= global_event_flag_gpio_q | gpio_set;
      end
   end

   // enable registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         global_event_enable_first_q <= RST_EN_FIRST;
         global_event_enable_second_q <= RST_EN_SECOND;
         global_event_enable_gpio_q <= RST_EN_GPIO;
         global_event_enable_q <= 1'b0;
      end else begin
         if (wr_hit(bus, OFF_EN_FIRST)) begin
            global_event_enable_first_q <= bus.wdata;
         end
         if (wr_hit(bus, OFF_EN_SECOND)) begin
            global_event_enable_second_q <= bus.wdata & EN2_WR_MASK;
         end
         if (wr_hit(bus, OFF_EN_GPIO)) begin
            global_event_enable_gpio_q <= bus.wdata;
         end
         if (wr_hit(bus, OFF_GLB_EN)) begin
            global_event_enable_q <= bus.wdata[BIT_GLB];
         end
      end
   end

   // per-source gating onto the global flag
   assign pending =
      (|(global_event_flag_first_q & global_event_enable_first_q)) ||
      (|(global_event_flag_second & global_event_enable_second_q & SRC2_MASK)) ||
      (|(global_event_flag_gpio_q & global_event_enable_gpio_q));

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         global_event_flag_q <= 1'b0;
      end else if (pending) begin
         global_event_flag_q <= 1'b1;
      end else if (wr_hit(bus, OFF_GLB_STS) && bus.wdata[BIT_GLB]) begin
         global_event_flag_q <= 1'b0;
      end
   end

   assign smi_func = global_event_flag_q &&
                     global_event_enable_q;

   // routed outputs come from flip-flops so source changes cannot glitch them
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         smi_pin_n_q <= 1'b1;
         serirq_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         smi_pin_n_q <= !(smi_func &&
                          global_event_enable_second_q[BIT_ROUTE_PIN]);
         serirq_q <= smi_func &&
                     global_event_enable_second_q[BIT_ROUTE_SERIRQ];
         wake_q <= smi_func &&
                   global_event_enable_second_q[BIT_ROUTE_WAKE];
      end
   end

   assign sys_mgmt_irq_n_pin = smi_pin_n_q;
   assign serirq_smi = serirq_q;
   assign wake_devint = wake_q;

   // host interrupt: sticky events, write-one clear, enable mask
   always_comb begin
      irq_ev = RST_IRQ;
      irq_ev[IRQ_GLB] = pending && !global_event_flag_q;
      irq_ev[IRQ_GPIO] = |gpio_set;
      irq_ev[IRQ_WDT] = src.wd_expired;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_sts_q <= RST_IRQ;
      end else if (wr_hit(bus, OFF_IRQ_CLR)) begin
         irq_sts_q <= (irq_sts_q & ~bus.wdata[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_sts_q <= irq_sts_q | irq_ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_en_q <= RST_IRQ;
      end else if (wr_hit(bus, OFF_IRQ_EN)) begin
         irq_en_q <= bus.wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_sts_q & irq_en_q);

   // read port: data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rd_data_q <= RST_BYTE;
      end else if (bus.rd) begin
         case (bus.addr)
            OFF_GLB_STS: rd_data_q <= {7'h00, global_event_flag_q};
            OFF_GLB_EN: rd_data_q <= {7'h00, global_event_enable_q};
            OFF_STS_FIRST: rd_data_q <= global_event_flag_first_q;
            OFF_STS_SECOND: rd_data_q <= global_event_flag_second;
            OFF_STS_GPIO: rd_data_q <= global_event_flag_gpio_q;
            OFF_EN_FIRST: rd_data_q <= global_event_enable_first_q;
            OFF_EN_SECOND: rd_data_q <= global_event_enable_second_q;
            OFF_EN_GPIO: rd_data_q <= global_event_enable_gpio_q;
            OFF_IRQ_STS: rd_data_q <= {5'h00, irq_sts_q};
            OFF_IRQ_EN: rd_data_q <= {5'h00, irq_en_q};
            default: rd_data_q <= RST_BYTE;
         endcase
      end else begin
         rd_data_q <= RST_BYTE;
      end
   end

   assign rd_data = rd_data_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   mouse_follow_a: assert property (
      ##1 mouse_irq_flag_q == $past(src.mouse_irq))
      else $error("mouse status does not follow its source");
   kbd_follow_a: assert property (
      ##1 keyboard_irq_flag_q == $past(src.kbd_irq))
      else $error("keyboard status does not follow its source");
   intr_copy_a: assert property (
      src.intrusion [*2] |-> intrusion_q)
      else $error("intrusion status does not copy its flag");
   intr_clear_a: assert property (
      !src.intrusion |=> !intrusion_q)
      else $error("intrusion status outlives its flag");
   rsvd_one_a: assert property (
      (bus.rd && bus.addr == OFF_STS_SECOND) |=> rd_data[BIT_RSVD])
      else $error("reserved status bit read as zero");

   wdt_sticky_a: assert property (
      src.wd_expired |=> watchdog_timeout_flag_q)
      else $error("watchdog flag not set on timeout");
   wdt_hold_a: assert property (
      (watchdog_timeout_flag_q &&
       !(wr_hit(bus, OFF_STS_SECOND) && bus.wdata[BIT_WDT])) |=>
      watchdog_timeout_flag_q)
      else $error("watchdog flag lost without a clearing write");
   wdt_clear_a: assert property (
      (wr_hit(bus, OFF_STS_SECOND) && bus.wdata[BIT_WDT] &&
       !src.wd_expired) |=> !watchdog_timeout_flag_q)
      else $error("watchdog flag not cleared by a written one");

   gpio_clear_a: assert property (
      (wr_hit(bus, OFF_STS_GPIO) && gpio_set == 8'h00) |=>
      ((global_event_flag_gpio_q & $past(bus.wdata)) == 8'h00))
      else $error("gpio status bit not cleared by one");
   gpio_keep_a: assert property (
      wr_hit(bus, OFF_STS_GPIO) |=> ((~global_event_flag_gpio_q &
         $past(global_event_flag_gpio_q) & ~$past(bus.wdata)) == 8'h00))
      else $error("gpio status bit lost on a written zero");
   gpio_level_a: assert property (
      (global_event_flag_gpio_q & ~$past(global_event_flag_gpio_q) &
       ~$past(edge_sel)) == 8'h00)
      else $error("gpio status set under a level setting");
   gpio_map_a: assert property (
      (gpio_det[7] == DET_RISE && gpio_pin[7] && !pin_q[7]) |=>
      global_event_flag_gpio_q[7])
      else $error("top gpio event not recorded in bit 7");
   gpio_arm_a: assert property (
      (edge_sel[0] && det_q[0] == DET_NONE && gpio_pin[0]) |=>
      global_event_flag_gpio_q[0])
      else $error("arming edge mode with pin high did not set status");

   first_gate_a: assert property (
      ((src.first & global_event_enable_first_q) != 8'h00 &&
       !wr_hit(bus, OFF_EN_FIRST)) |=> ##1 global_event_flag_q)
      else $error("first status source did not reach global flag");
   en2_gate_a: assert property (
      (mouse_irq_flag_q && global_event_enable_second_q[BIT_MOUSE]) |=>
      global_event_flag_q)
      else $error("enabled mouse status did not reach global flag");
   en2_rsvd_a: assert property (
      !global_event_enable_second_q[BIT_RSVD])
      else $error("read-only enable bit became set");
   gpio_gate_a: assert property (
      ((global_event_flag_gpio_q & global_event_enable_gpio_q) != 8'h00) |=>
      global_event_flag_q)
      else $error("enabled gpio status did not reach global flag");
   glb_set_a: assert property (
      pending |=> global_event_flag_q [*1])
      else $error("global flag not set by an enabled source");
   glb_hold_a: assert property (
      (global_event_flag_q && !(wr_hit(bus, OFF_GLB_STS) &&
       bus.wdata[BIT_GLB])) |=> global_event_flag_q)
      else $error("global flag lost without a clearing write");

   glb_block_a: assert property (
      !global_event_enable_q |=>
      (sys_mgmt_irq_n_pin && !serirq_smi && !wake_devint))
      else $error("smi routed while globally disabled");
   route_pin_a: assert property (
      (smi_func && global_event_enable_second_q[BIT_ROUTE_PIN]) |=>
      !sys_mgmt_irq_n_pin)
      else $error("smi pin not driven low");
   route_serirq_a: assert property (
      ##1 serirq_smi == $past(smi_func &&
         global_event_enable_second_q[BIT_ROUTE_SERIRQ]))
      else $error("serial irq route mismatch");
   route_wake_a: assert property (
      ##1 wake_devint == $past(smi_func &&
         global_event_enable_second_q[BIT_ROUTE_WAKE]))
      else $error("wake route mismatch");
   pin_reg_a: assert property (
      ##1 sys_mgmt_irq_n_pin == !$past(smi_func &&
         global_event_enable_second_q[BIT_ROUTE_PIN]))
      else $error("smi pin not a registered copy of its route");

endmodule

/* File: tb/ssa_host_model.sv */
// host chipset model: counts assertions of the dedicated smi pin
`timescale 1ns/1ps
module ssa_host_model (
   input wire logic clk_sys,   // system clock
   input wire logic nrst,      // synchronous reset, active low
   input wire logic smi_n,     // dedicated smi pin, active low
   output logic [7:0] pin_cnt  // falling edges seen on the pin
);
   logic smi_n_q;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         smi_n_q <= 1'b1;
         pin_cnt <= 8'h00;
      end else begin
         smi_n_q <= smi_n;
         if (smi_n_q && !smi_n) begin
            pin_cnt <= pin_cnt + 8'h01;
         end
      end
   end
endmodule

/* File: tb/ssa_top_test.sv */
// self-checking bench of the smi source aggregator
`timescale 1ns/1ps
module ssa_top_test
   import ssa_pkg::*;
;
   logic clk_sys;
   logic nrst;
   ssa_bus_t bus;
   logic [7:0] rd_data;
   ssa_src_t src;
   logic [7:0] gpio_pin;
   ssa_det_t [7:0] gpio_det;
   logic smi_n;
   logic serirq_smi;
   logic wake_devint;
   logic irq;
   logic [7:0] pin_cnt;
   int fail_count;
   int n_checks;

   ssa_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
      .rd_data(rd_data), .src(src), .gpio_pin(gpio_pin),
      .gpio_det(gpio_det), .sys_mgmt_irq_n_pin(smi_n),
      .serirq_smi(serirq_smi), .wake_devint(wake_devint), .irq(irq));
   ssa_host_model i_host (.clk_sys(clk_sys), .nrst(nrst),
      .smi_n(smi_n), .pin_cnt(pin_cnt));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 check(rd_data, exp);
   endtask
   task automatic set_src(input logic [11:0] v);
      @(posedge clk_sys);
      src <= v;
   endtask
   task automatic set_det(input ssa_det_t d);
      @(posedge clk_sys);
      foreach (gpio_det[i]) gpio_det[i] <= d;
   endtask
   // order: pin active, serial irq, wake device interrupt
   task automatic outs(input logic [2:0] exp);
      #1 check({5'h00, ~smi_n, serirq_smi, wake_devint}, {5'h00, exp});
   endtask

   task automatic t_reset;
      rdc(OFF_EN_FIRST, 8'h00);
      rdc(OFF_EN_SECOND, 8'h00);
      rdc(OFF_EN_GPIO, 8'h00);
      rdc(OFF_STS_SECOND, 8'h04);
      tick(1);
      #1 check(rd_data, 8'h00);
      outs(3'b000);
      $display("reset values done");
   endtask
   task automatic t_mirror;
      set_src(12'h008);
      rdc(OFF_STS_SECOND, 8'h05);
      set_src(12'h004);
      rdc(OFF_STS_SECOND, 8'h06);
      wr(OFF_STS_SECOND, 8'hFF);
      rdc(OFF_STS_SECOND, 8'h06);
      set_src(12'h001);
      wr(OFF_STS_SECOND, 8'hFF);
      rdc(OFF_STS_SECOND, 8'h14);
      set_src(12'h000);
      rdc(OFF_STS_SECOND, 8'h04);
      set_src(12'h002);
      set_src(12'h000);
      rdc(OFF_STS_SECOND, 8'h0C);
      wr(OFF_STS_SECOND, 8'h00);
      rdc(OFF_STS_SECOND, 8'h0C);
      wr(OFF_STS_SECOND, 8'h08);
      rdc(OFF_STS_SECOND, 8'h04);
      $display("second status done");
   endtask
   task automatic t_gpio;
      logic [7:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         @(posedge clk_sys);
         gpio_det[i] <= DET_RISE;
         rdc(OFF_STS_GPIO, 8'h00);
         @(posedge clk_sys);
         gpio_pin <= m;
         rdc(OFF_STS_GPIO, m);
         wr(OFF_STS_GPIO, 8'h00);
         rdc(OFF_STS_GPIO, m);
         wr(OFF_STS_GPIO, m);
         rdc(OFF_STS_GPIO, 8'h00);
         @(posedge clk_sys);
         gpio_pin <= 8'h00;
         rdc(OFF_STS_GPIO, 8'h00);
      end
      set_det(DET_LEVEL_HIGH);
      gpio_pin <= 8'hFF;
      rdc(OFF_STS_GPIO, 8'h00);
      set_det(DET_NONE);
      set_det(DET_BOTH);
      rdc(OFF_STS_GPIO, 8'hFF);
      wr(OFF_STS_GPIO, 8'hFF);
      @(posedge clk_sys);
      gpio_pin <= 8'h00;
      rdc(OFF_STS_GPIO, 8'hFF);
      wr(OFF_STS_GPIO, 8'hFF);
      set_det(DET_LEVEL_LOW);
      rdc(OFF_STS_GPIO, 8'h00);
      set_det(DET_FALL);
      gpio_pin <= 8'hFF;
      rdc(OFF_STS_GPIO, 8'h00);
      @(posedge clk_sys);
      gpio_pin <= 8'h00;
      rdc(OFF_STS_GPIO, 8'hFF);
      wr(OFF_STS_GPIO, 8'hFF);
      set_det(DET_BOTH);
      $display("gpio status done");
   endtask
   task automatic t_route;
      wr(OFF_EN_SECOND, 8'hE1);
      set_src(12'h008);
      tick(4);
      outs(3'b000);
      rdc(OFF_GLB_STS, 8'h01);
      wr(OFF_GLB_EN, 8'h01);
      tick(2);
      outs(3'b111);
      wr(OFF_GLB_STS, 8'h01);
      rdc(OFF_GLB_STS, 8'h01);
      for (int k = 5; k < 8; k++) begin
         wr(OFF_EN_SECOND, 8'h01 | (8'h01 << k));
         tick(2);
         outs({k == 7, k == 6, k == 5});
      end
      check(pin_cnt, 8'h02);
      set_src(12'h000);
      wr(OFF_GLB_STS, 8'h01);
      tick(2);
      outs(3'b000);
      $display("routing done");
   endtask
   task automatic t_gate;
      wr(OFF_EN_SECOND, 8'hFF);
      rdc(OFF_EN_SECOND, 8'hFB);
      wr(OFF_EN_SECOND, 8'hE4);
      set_src(12'h08F);
      tick(4);
      rdc(OFF_GLB_STS, 8'h00);
      rdc(OFF_STS_FIRST, 8'h08);
      wr(OFF_EN_FIRST, 8'h08);
      tick(3);
      outs(3'b111);
      wr(OFF_EN_FIRST, 8'h00);
      wr(OFF_GLB_STS, 8'h01);
      tick(2);
      outs(3'b000);
      @(posedge clk_sys);
      gpio_pin <= 8'h01;
      wr(OFF_EN_GPIO, 8'h02);
      tick(3);
      rdc(OFF_GLB_STS, 8'h00);
      wr(OFF_EN_GPIO, 8'h01);
      tick(3);
      outs(3'b111);
      set_src(12'h000);
      wr(OFF_EN_GPIO, 8'h00);
      wr(OFF_STS_GPIO, 8'hFF);
      wr(OFF_STS_SECOND, 8'h08);
      wr(OFF_GLB_STS, 8'h01);
      tick(2);
      outs(3'b000);
      $display("gating done");
   endtask
   task automatic t_irq;
      wr(OFF_IRQ_CLR, 8'h07);
      wr(OFF_IRQ_EN, 8'h04);
      set_src(12'h002);
      set_src(12'h000);
      tick(2);
      #1 check({7'h00, irq}, 8'h01);
      wr(OFF_IRQ_EN, 8'h00);
      #1 check({7'h00, irq}, 8'h00);
      rdc(OFF_IRQ_STS, 8'h04);
      wr(OFF_IRQ_EN, 8'h04);
      wr(OFF_IRQ_CLR, 8'h04);
      #1 check({7'h00, irq}, 8'h00);
      rdc(OFF_IRQ_STS, 8'h00);
      rdc(OFF_IRQ_CLR, 8'h00);
      wr(8'h30, 8'hFF);
      rdc(8'h30, 8'h00);
      $display("host interrupt done");
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      nrst = 1'b0;
      bus = '0;
      src = '0;
      gpio_pin = 8'h00;
      foreach (gpio_det[i]) gpio_det[i] = DET_NONE;
      fail_count = 0;
      n_checks = 0;
      tick(8);
      nrst <= 1'b1;
      t_reset;
      t_mirror;
      t_gpio;
      t_route;
      t_gate;
      t_irq;
      close_out;
   end
   // the tests need well under 2000 cycles
   initial begin
      #200000;
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out;
   end
endmodule
